// >>> sim/usbetc_host.sv
// Behavioural USB host that sends tokens and packets and takes IN data.
`timescale 1ns/10ps
module usbetc_host
   import usbetc_pkg::*;
(
   input  wire logic            pclk,
   output logic                 tok_valid,
   output logic [1:0]           tok_pid,
   output logic [EP_W-1:0]      tok_ep,
   output logic                 rx_valid,
   output logic [7:0]           rx_data,
   output logic                 rx_end,
   output logic                 rx_crc_ok,
   input  wire logic            hs_valid,
   input  wire logic            hs_nak,
   input  wire logic            tx_valid,
   input  wire logic [7:0]      tx_data,
   input  wire logic            tx_last,
   input  wire logic            tx_zlp,
   output logic                 tx_ready,
   output logic                 in_ack
);
   logic       slow = 1'h0;
   logic       zlp;
   logic [7:0] got[$];
   initial begin
      {tok_valid, tok_pid, tok_ep, rx_valid, rx_data, rx_end, rx_crc_ok, tx_ready, in_ack} = '0;
   end
   // Idle lines show the inverse of their last value so that stale data never looks valid.
   task automatic tok(input logic [1:0] p, input logic [EP_W-1:0] ep);
      @(posedge pclk);
      tok_valid <= 1'h1;
      tok_pid <= p;
      tok_ep <= ep;
      @(posedge pclk);
      tok_valid <= 1'h0;
      tok_pid <= ~p;
      tok_ep <= ~ep;
   endtask
   // Result codes: 0 no answer, 1 acknowledged or data, 2 refused with a nak.
   task automatic out_pkt(input logic [1:0] p, input logic [EP_W-1:0] ep, input int n,
                          input logic crc, output logic [1:0] r);
      tok(p, ep);
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'h1;
         rx_data <= 8'hA0 + 8'(i);
         @(posedge pclk);
      end
      rx_valid <= 1'h0;
      rx_end <= 1'h1;
      rx_crc_ok <= crc;
      @(posedge pclk);
      rx_end <= 1'h0;
      rx_crc_ok <= ~crc;
      rx_data <= ~rx_data;
      r = 2'h0;
      repeat (4) begin
         @(posedge pclk);
         if (hs_valid && r == 2'h0) r = hs_nak ? 2'h2 : 2'h1;
      end
   endtask
   task automatic in_req(input logic [EP_W-1:0] ep, input logic ack, output logic [1:0] r);
      int k;
      got.delete();
      zlp = 1'h0;
      r = 2'h0;
      k = 0;
      tok(TOK_IN, ep);
      while (r == 2'h0 && k < 40) begin
         tx_ready <= slow ? ~tx_ready : 1'h1;
         @(posedge pclk);
         k++;
         if (hs_valid) r = 2'h2;
         else if (tx_valid && tx_ready) begin
            if (tx_zlp) zlp = 1'h1;
            else got.push_back(tx_data);
            if (tx_last) r = 2'h1;
         end
      end
      tx_ready <= 1'h0;
      in_ack <= ack && r == 2'h1;
      @(posedge pclk);
      in_ack <= 1'h0;
   endtask
endmodule

// >>> sim/usbetc_monitor.sv
// Concurrent checks on the endpoint block ports.
`timescale 1ns/10ps
module usbetc_monitor
   import usbetc_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       tok_valid,
   input wire logic [1:0] tok_pid,
   input wire logic       rx_end,
   input wire logic       rx_crc_ok,
   input wire logic       hs_valid,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_last,
   input wire logic       tx_zlp,
   input wire logic       tx_ready
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   error_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   bad_crc_a: assert property (rx_end && !rx_crc_ok |=> !hs_valid [*2])
      else $error("handshake after bad crc");
   hs_cause_a: assert property (hs_valid |->
      $past(rx_end && rx_crc_ok) || $past(tok_valid && tok_pid == TOK_IN))
      else $error("handshake without cause");
   nak_no_data_a: assert property (hs_valid |-> !tx_valid)
      else $error("data beside handshake");
   tx_start_a: assert property ($rose(tx_valid) |-> $past(tok_valid && tok_pid == TOK_IN, 2))
      else $error("data without in token");
   tx_hold_a: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_last) && (tx_zlp || $stable(tx_data)))
      else $error("beat dropped while stalled");
   zlp_last_a: assert property (tx_valid && tx_zlp |-> tx_last)
      else $error("empty packet not last");
   tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
      else $error("data after last beat");
endmodule

// >>> sim/usbetc_top_test.sv
// Self-checking bench for the endpoint transaction controller.
`timescale 1ns/10ps
module usbetc_top_test;
   import usbetc_pkg::*;
   typedef struct packed {
      logic       clr;
      logic [7:0] n;
      logic       crc;
      logic [1:0] hs;
      logic [7:0] st;
      logic [7:0] cnt;
   } usbetc_row_t;
   logic              pclk = 1'h0;
   logic              presetn = 1'h0;
   logic              psel = 1'h0;
   logic              penable = 1'h0;
   logic              pwrite = 1'h0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [31:0]       prdata, q;
   logic [1:0]        tok_pid, h;
   logic [EP_W-1:0]   tok_ep;
   logic [7:0]        rx_data, tx_data;
   logic              pready, pslverr, perr, tok_valid, rx_valid, rx_end, rx_crc_ok;
   logic              hs_valid, hs_nak, tx_valid, tx_last, tx_zlp, tx_ready, in_ack;
   int                errors = 0;
   int                compares = 0;
   int                cyc = 0;
   // A count of FF means the count register is not compared in that row.
   usbetc_row_t rows [6] = '{
      '{1'h0, 8'h03, 1'h1, 2'h1, 8'h02, 8'h03},
      '{1'h0, 8'h02, 1'h1, 2'h2, 8'h02, 8'h03},
      '{1'h1, 8'h00, 1'h1, 2'h1, 8'h02, 8'h00},
      '{1'h1, 8'h28, 1'h1, 2'h1, 8'h02, 8'h28},
      '{1'h1, 8'h04, 1'h0, 2'h0, 8'h00, 8'hFF},
      '{1'h0, 8'h03, 1'h1, 2'h1, 8'h02, 8'h03}};
   usbetc_top i_dut (.*);
   usbetc_host i_host (.*);
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic rdd(input logic [7:0] e);
      apb(1'h0, ADDR_EP_DATA, 32'h0);
      chk({24'h0, q[7:0]}, {24'h0, e});
   endtask
   task automatic pkt(input logic [1:0] p, input logic [1:0] ep, input int n, input logic c, input logic [1:0] e);
      i_host.out_pkt(p, ep, n, c, h);
      chk({30'h0, h}, {30'h0, e});
   endtask
   task automatic inq(input logic [1:0] ep, input logic ack, input logic [1:0] e, input int n);
      i_host.in_req(ep, ack, h);
      chk({30'h0, h}, {30'h0, e});
      chk(32'(i_host.got.size()), 32'(n));
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      rdc(ADDR_EP_SELECT, REG_RESET);
      rdc(ADDR_EP_CONFIG, REG_RESET);
      rdc(ADDR_EP_STATUS, REG_RESET);
      rdc(12'h020, 32'h0);
      chk({31'h0, perr}, 32'h1);
      pkt(TOK_OUT, 2'h1, 3, 1'h1, 2'h0);
      wr(ADDR_EP_SELECT, 32'h1);
      wr(ADDR_EP_CONFIG, 32'h82);
      foreach (rows[i]) begin
         if (rows[i].clr) wr(ADDR_EP_STATUS, 32'h0);
         pkt(TOK_OUT, 2'h1, int'(rows[i].n), rows[i].crc, rows[i].hs);
         rdc(ADDR_EP_STATUS, {24'h0, rows[i].st});
         if (rows[i].cnt !== 8'hFF) rdc(ADDR_EP_COUNT, {24'h0, rows[i].cnt});
      end
      for (int i = 0; i < 3; i++) rdd(8'hA0 + 8'(i));
      rdc(ADDR_EP_COUNT, 32'h3);
      wr(ADDR_EP_STATUS, 32'h2);
      rdc(ADDR_EP_STATUS, 32'h2);
      wr(ADDR_EP_STATUS, 32'h0);
      inq(2'h1, 1'h1, 2'h0, 0);
      wr(ADDR_EP_CONFIG, 32'h8A);
      pkt(TOK_OUT, 2'h1, 2, 1'h1, 2'h1);
      rdc(ADDR_EP_STATUS, 32'h02);
      pkt(TOK_OUT, 2'h1, 2, 1'h1, 2'h1);
      rdc(ADDR_EP_STATUS, 32'h42);
      pkt(TOK_OUT, 2'h1, 2, 1'h1, 2'h2);
      wr(ADDR_EP_STATUS, 32'h40);
      pkt(TOK_OUT, 2'h1, 2, 1'h1, 2'h1);
      rdc(ADDR_EP_STATUS, 32'h42);
      wr(ADDR_EP_SELECT, 32'h2);
      wr(ADDR_EP_CONFIG, 32'h86);
      inq(2'h2, 1'h1, 2'h2, 0);
      wr(ADDR_EP_DATA, 32'hC0);
      wr(ADDR_EP_DATA, 32'hC1);
      wr(ADDR_EP_STATUS, 32'h10);
      i_host.slow = 1'h1;
      inq(2'h2, 1'h1, 2'h1, 2);
      chk({16'h0, i_host.got[0], i_host.got[1]}, 32'hC0C1);
      i_host.slow = 1'h0;
      rdc(ADDR_EP_STATUS, 32'h01);
      wr(ADDR_EP_STATUS, 32'h0);
      wr(ADDR_EP_STATUS, 32'h10);
      inq(2'h2, 1'h0, 2'h1, 0);
      rdc(ADDR_EP_STATUS, 32'h10);
      inq(2'h2, 1'h1, 2'h1, 0);
      chk({31'h0, i_host.zlp}, 32'h1);
      rdc(ADDR_EP_STATUS, 32'h01);
      wr(ADDR_EP_STATUS, 32'h0);
      wr(ADDR_EP_DATA, 32'hE0);
      wr(ADDR_EP_STATUS, 32'h10);
      wr(ADDR_EP_STATUS, 32'h0);
      inq(2'h2, 1'h1, 2'h2, 0);
      wr(ADDR_EP_DATA, 32'hE1);
      wr(ADDR_EP_STATUS, 32'h10);
      inq(2'h2, 1'h1, 2'h1, 1);
      chk({24'h0, i_host.got[0]}, 32'hE1);
      wr(ADDR_EP_STATUS, 32'h0);
      wr(ADDR_EP_CONFIG, 32'h8E);
      wr(ADDR_EP_DATA, 32'hD0);
      wr(ADDR_EP_STATUS, 32'h10);
      wr(ADDR_EP_DATA, 32'hD1);
      wr(ADDR_EP_STATUS, 32'h10);
      inq(2'h2, 1'h1, 2'h1, 1);
      chk({24'h0, i_host.got[0]}, 32'hD0);
      inq(2'h2, 1'h1, 2'h1, 1);
      chk({24'h0, i_host.got[0]}, 32'hD1);
      inq(2'h2, 1'h1, 2'h2, 0);
      wr(ADDR_EP_SELECT, 32'h0);
      wr(ADDR_EP_CONFIG, 32'h80);
      wr(ADDR_EP_DATA, 32'hF0);
      wr(ADDR_EP_STATUS, 32'h90);
      pkt(TOK_SETUP, 2'h0, 8, 1'h1, 2'h1);
      rdc(ADDR_EP_STATUS, 32'h04);
      rdc(ADDR_EP_COUNT, 32'h08);
      wr(ADDR_EP_STATUS, 32'h0);
      pkt(TOK_OUT, 2'h0, 2, 1'h1, 2'h1);
      rdc(ADDR_EP_STATUS, 32'h02);
      rdd(8'hA0);
      wr(ADDR_EP_STATUS, 32'h0);
      pkt(TOK_OUT, 2'h0, 1, 1'h1, 2'h1);
      rdd(8'hA0);
      wr(ADDR_EP_SELECT, 32'h1);
      wr(ADDR_EP_CONFIG, 32'h81);
      pkt(TOK_OUT, 2'h1, 2, 1'h1, 2'h0);
      pkt(TOK_SETUP, 2'h1, 2, 1'h1, 2'h0);
      wr(ADDR_EP_SELECT, 32'h3);
      rdc(ADDR_EP_STATUS, 32'h0);
      chk({31'h0, perr}, 32'h1);
      // A reset in mid-run must bring the select and config registers back to their idle value.
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rdc(ADDR_EP_SELECT, REG_RESET);
      rdc(ADDR_EP_CONFIG, REG_RESET);
      wrap_up();
   end
endmodule
bind usbetc_top usbetc_monitor i_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .tok_valid,
   .tok_pid, .rx_end, .rx_crc_ok, .hs_valid, .tx_valid, .tx_data, .tx_last, .tx_zlp, .tx_ready);

// >>> verilog/usbetc_pkg.sv
// Shared constants for the USB endpoint transaction controller.
package usbetc_pkg;
   localparam int NUM_EP     = 3;
   localparam int EP_W       = 2;
   localparam int FIFO_DEPTH = 32;
   localparam int PTR_W      = 6;
   localparam int IDX_W      = 5;
   localparam int CNT_W      = 8;
   localparam int ADDR_W     = 12;

   localparam logic [ADDR_W-1:0] ADDR_EP_SELECT = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_EP_CONFIG = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_EP_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_EP_DATA   = 12'h00C;
   localparam logic [ADDR_W-1:0] ADDR_EP_COUNT  = 12'h010;

   // Endpoint status field positions.
   localparam int ST_TX_DONE  = 0;
   localparam int ST_RX0      = 1;
   localparam int ST_SETUP    = 2;
   localparam int ST_TX_READY = 4;
   localparam int ST_RX1      = 6;
   localparam int ST_DIR      = 7;

   // Endpoint configuration field positions.
   localparam int CF_TYPE_LO  = 0;
   localparam int CF_DIR      = 2;
   localparam int CF_PINGPONG = 3;
   localparam int CF_ENABLE   = 7;

   localparam logic [1:0] EP_TYPE_CONTROL = 2'h0;
   localparam logic [1:0] EP_TYPE_ISO     = 2'h1;

   localparam logic [1:0] TOK_OUT   = 2'h0;
   localparam logic [1:0] TOK_IN    = 2'h1;
   localparam logic [1:0] TOK_SETUP = 2'h2;

   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      S_IDLE     = 2'b00,
      S_RX       = 2'b01,
      S_TX       = 2'b10,
      S_WAIT_ACK = 2'b11
   } usbetc_state_e_t;
endpackage

// >>> verilog/usbetc_top.sv
// Endpoint transaction handshake logic with APB register access.
`timescale 1ns/10ps
module usbetc_top
   import usbetc_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                tok_valid,
   input  wire logic [1:0]          tok_pid,
   input  wire logic [EP_W-1:0]     tok_ep,
   input  wire logic                rx_valid,
   input  wire logic [7:0]          rx_data,
   input  wire logic                rx_end,
   input  wire logic                rx_crc_ok,
   output logic                     hs_valid,
   output logic                     hs_nak,
   output logic                     tx_valid,
   output logic      [7:0]          tx_data,
   output logic                     tx_last,
   output logic                     tx_zlp,
   input  wire logic                tx_ready,
   input  wire logic                in_ack
);
   typedef struct packed {
      usbetc_state_e_t                               st;
      logic [EP_W-1:0]                               sel;
      logic [NUM_EP-1:0]                             en;
      logic [NUM_EP-1:0]                             pp;
      logic [NUM_EP-1:0]                             cdir;
      logic [NUM_EP-1:0][1:0]                        ty;
      logic [NUM_EP-1:0]                             rx0;
      logic [NUM_EP-1:0]                             rx1;
      logic [NUM_EP-1:0]                             setup;
      logic [NUM_EP-1:0]                             txdone;
      logic [NUM_EP-1:0]                             sdir;
      logic [NUM_EP-1:0][1:0]                        tx_packet_ready_flag;
      logic [NUM_EP-1:0]                             rxbank;
      logic [NUM_EP-1:0]                             fwbank;
      logic [NUM_EP-1:0]                             txbank;
      logic [NUM_EP-1:0][PTR_W-1:0]                  fwptr;
      logic [NUM_EP-1:0][1:0][CNT_W-1:0]             cnt;
      logic [NUM_EP-1:0][1:0][FIFO_DEPTH-1:0][7:0]   mem;
      logic [EP_W-1:0]                               cur_ep;
      logic                                          cur_bank;
      logic                                          cur_acc;
      logic                                          cur_setup;
      logic [CNT_W-1:0]                              cur_cnt;
      logic [PTR_W-1:0]                              txidx;
      logic                                          hs_valid;
      logic                                          hs_nak;
      logic                                          tx_valid;
      logic                                          tx_last;
      logic                                          tx_zlp;
      logic [7:0]                                    tx_data;
      logic [31:0]                                   prdata;
      logic                                          pready;
      logic                                          pslverr;
   } usbetc_regs_t;
   usbetc_regs_t q_q;
   usbetc_regs_t q_d;
   always_comb begin
      logic [EP_W-1:0] e;
      logic [EP_W-1:0] k;
      logic            b;
      logic            sel_ok;
      logic            is_ctl;
      logic [31:0]     rd;
      e      = q_q.sel;
      k      = tok_ep;
      b      = 1'b0;
      sel_ok = (q_q.sel < EP_W'(NUM_EP));
      is_ctl = 1'b0;
      rd     = REG_RESET;
      q_d    = q_q;
      q_d.hs_valid = 1'b0;
      // Register read data is built in the setup cycle so that it leaves a flop.
      if (psel && !penable && !q_q.pready) begin
         q_d.pready  = 1'b1;
         q_d.pslverr = 1'b0;
         b = q_q.fwbank[e];
         if (paddr == ADDR_EP_SELECT) begin
            rd[EP_W-1:0] = q_q.sel;
         end else if (!sel_ok) begin
            q_d.pslverr = 1'b1;
         end else begin
            case (paddr)
               ADDR_EP_CONFIG: begin
                  rd[CF_ENABLE]              = q_q.en[e];
                  rd[CF_PINGPONG]            = q_q.pp[e];
                  rd[CF_DIR]                 = q_q.cdir[e];
                  rd[CF_TYPE_LO+1:CF_TYPE_LO] = q_q.ty[e];
               end
               ADDR_EP_STATUS: begin
                  rd[ST_TX_DONE]  = q_q.txdone[e];
                  rd[ST_RX0]      = q_q.rx0[e];
                  rd[ST_SETUP]    = q_q.setup[e];
                  rd[ST_TX_READY] = q_q.tx_packet_ready_flag[e][b];
                  rd[ST_RX1]      = q_q.rx1[e];
                  rd[ST_DIR]      = q_q.sdir[e];
               end
               ADDR_EP_DATA:  rd[7:0] = q_q.mem[e][b][q_q.fwptr[e][IDX_W-1:0]];
               ADDR_EP_COUNT: rd[CNT_W-1:0] = q_q.cnt[e][b];
               default:       q_d.pslverr = 1'b1;
            endcase
         end
         q_d.prdata = rd;
      end else if (psel && penable && q_q.pready) begin
         q_d.pready  = 1'b0;
         q_d.pslverr = 1'b0;
         b = q_q.fwbank[e];
         if (!q_q.pslverr && pwrite) begin
            case (paddr)
               ADDR_EP_SELECT: q_d.sel = pwdata[EP_W-1:0];
               ADDR_EP_CONFIG: begin
                  q_d.en[e]   = pwdata[CF_ENABLE];
                  q_d.pp[e]   = pwdata[CF_PINGPONG];
                  q_d.cdir[e] = pwdata[CF_DIR];
                  q_d.ty[e]   = pwdata[CF_TYPE_LO+1:CF_TYPE_LO];
               end
               ADDR_EP_STATUS: begin
                  // Writing one to a done, receive or setup flag leaves it alone, so read-modify-write is safe.
                  if (!pwdata[ST_TX_DONE]) q_d.txdone[e] = 1'b0;
                  if (!pwdata[ST_RX0] && q_q.rx0[e]) begin
                     q_d.rx0[e]   = 1'b0;
                     q_d.fwptr[e] = '0;
                     if (q_q.pp[e] && !q_q.fwbank[e]) q_d.fwbank[e] = 1'b1;
                  end
                  if (!pwdata[ST_RX1] && q_q.rx1[e]) begin
                     q_d.rx1[e]   = 1'b0;
                     q_d.fwptr[e] = '0;
                     if (q_q.pp[e] && q_q.fwbank[e]) q_d.fwbank[e] = 1'b0;
                  end
                  if (!pwdata[ST_SETUP] && q_q.setup[e]) begin
                     q_d.setup[e] = 1'b0;
                     q_d.fwptr[e] = '0;
                  end
                  q_d.sdir[e] = pwdata[ST_DIR];
                  if (pwdata[ST_TX_READY] && !q_q.tx_packet_ready_flag[e][b]) begin
                     q_d.tx_packet_ready_flag[e][b] = 1'b1;
                     q_d.cnt[e][b]   = CNT_W'(q_q.fwptr[e]);
                     q_d.fwptr[e]    = '0;
                     if (q_q.pp[e]) q_d.fwbank[e] = ~b;
                  end else if (!pwdata[ST_TX_READY] && q_q.tx_packet_ready_flag[e][b]) begin
                     q_d.tx_packet_ready_flag[e]  = 2'h0;
                     q_d.cnt[e]    = '0;
                     q_d.fwptr[e]  = '0;
                     q_d.fwbank[e] = q_q.txbank[e];
                  end
               end
               ADDR_EP_DATA: begin
                  if (q_q.fwptr[e] < PTR_W'(FIFO_DEPTH)) begin
                     q_d.mem[e][b][q_q.fwptr[e][IDX_W-1:0]] = pwdata[7:0];
                     q_d.fwptr[e] = q_q.fwptr[e] + PTR_W'(1);
                  end
               end
               default: ;
            endcase
         end else if (!q_q.pslverr && paddr == ADDR_EP_DATA) begin
            if (q_q.fwptr[e] < PTR_W'(FIFO_DEPTH)) q_d.fwptr[e] = q_q.fwptr[e] + PTR_W'(1);
         end
      end
      // Link side runs after the register side, so a hardware set beats a firmware clear.
      case (q_q.st)
         S_RX: begin
            if (rx_valid) begin
               if (q_q.cur_acc && q_q.cur_cnt < CNT_W'(FIFO_DEPTH)) begin
                  q_d.mem[q_q.cur_ep][q_q.cur_bank][q_q.cur_cnt[IDX_W-1:0]] = rx_data;
               end
               if (q_q.cur_cnt != {CNT_W{1'b1}}) q_d.cur_cnt = q_q.cur_cnt + CNT_W'(1);
            end
            if (rx_end) begin
               q_d.st = S_IDLE;
               if (rx_crc_ok) begin
                  q_d.hs_valid = 1'b1;
                  q_d.hs_nak   = ~q_q.cur_acc;
                  if (q_q.cur_acc) begin
                     k = q_q.cur_ep;
                     q_d.cnt[k][q_q.cur_bank] = q_q.cur_cnt;
                     if (q_q.cur_setup) begin
                        q_d.setup[k]  = 1'b1;
                        q_d.rx0[k]    = 1'b0;
                        q_d.rx1[k]    = 1'b0;
                        q_d.txdone[k] = 1'b0;
                        q_d.tx_packet_ready_flag[k]  = 2'h0;
                        q_d.sdir[k]   = 1'b0;
                        q_d.fwptr[k]  = '0;
                     end else if (q_q.cur_bank) begin
                        q_d.rx1[k]    = 1'b1;
                        q_d.rxbank[k] = 1'b0;
                     end else begin
                        q_d.rx0[k]    = 1'b1;
                        q_d.rxbank[k] = q_q.pp[k];
                     end
                  end
               end
            end
         end
         S_TX: begin
            if (q_q.tx_valid && tx_ready && q_q.tx_last) begin
               q_d.tx_valid = 1'b0;
               q_d.tx_last  = 1'b0;
               q_d.tx_zlp   = 1'b0;
               q_d.st       = S_WAIT_ACK;
            end else if (!q_q.tx_valid || tx_ready) begin
               q_d.tx_valid = 1'b1;
               if (q_q.cnt[q_q.cur_ep][q_q.cur_bank] == '0) begin
                  q_d.tx_zlp  = 1'b1;
                  q_d.tx_last = 1'b1;
               end else begin
                  q_d.tx_data = q_q.mem[q_q.cur_ep][q_q.cur_bank][q_q.txidx[IDX_W-1:0]];
                  q_d.tx_last = (CNT_W'(q_q.txidx) + CNT_W'(1) == q_q.cnt[q_q.cur_ep][q_q.cur_bank]);
                  q_d.txidx   = q_q.txidx + PTR_W'(1);
               end
            end
         end
         S_WAIT_ACK: begin
            if (in_ack) begin
               q_d.st = S_IDLE;
               k = q_q.cur_ep;
               if (q_q.tx_packet_ready_flag[k][q_q.cur_bank]) begin
                  q_d.txdone[k] = 1'b1;
                  q_d.tx_packet_ready_flag[k][q_q.cur_bank] = 1'b0;
                  q_d.cnt[k][q_q.cur_bank]   = '0;
                  if (q_q.pp[k] && q_q.ty[k] != EP_TYPE_CONTROL) q_d.txbank[k] = ~q_q.cur_bank;
               end
            end
         end
         default: q_d.st = S_IDLE;
      endcase
      // A fresh token while an acknowledge is awaited means the host retries; the bank stays ready.
      if ((q_q.st == S_IDLE || q_q.st == S_WAIT_ACK) && tok_valid && tok_ep < EP_W'(NUM_EP)) begin
         k = tok_ep;
         is_ctl = (q_q.ty[k] == EP_TYPE_CONTROL);
         q_d.st        = S_IDLE;
         q_d.cur_ep    = k;
         q_d.cur_cnt   = '0;
         q_d.cur_setup = 1'b0;
         q_d.cur_acc   = 1'b0;
         q_d.cur_bank  = 1'b0;
         if (q_q.en[k]) begin
            case (tok_pid)
               TOK_SETUP: begin
                  if (is_ctl) begin
                     q_d.cur_acc   = 1'b1;
                     q_d.cur_setup = 1'b1;
                     q_d.st        = S_RX;
                  end
               end
               TOK_OUT: begin
                  if (is_ctl || (!q_q.cdir[k] && q_q.ty[k] != EP_TYPE_ISO)) begin
                     q_d.st = S_RX;
                     if (is_ctl || !q_q.pp[k]) begin
                        q_d.cur_acc = !q_q.rx0[k] && !q_q.setup[k];
                     end else begin
                        b = q_q.rxbank[k];
                        if (!(b ? q_q.rx1[k] : q_q.rx0[k])) begin
                           q_d.cur_acc  = 1'b1;
                           q_d.cur_bank = b;
                        end else if (!(b ? q_q.rx0[k] : q_q.rx1[k])) begin
                           q_d.cur_acc  = 1'b1;
                           q_d.cur_bank = ~b;
                        end
                     end
                  end
               end
               TOK_IN: begin
                  if (is_ctl || (q_q.cdir[k] && q_q.ty[k] != EP_TYPE_ISO)) begin
                     b = (is_ctl || !q_q.pp[k]) ? 1'b0 : q_q.txbank[k];
                     if (q_q.tx_packet_ready_flag[k][b]) begin
                        q_d.st       = S_TX;
                        q_d.cur_bank = b;
                        q_d.txidx    = '0;
                     end else begin
                        q_d.hs_valid = 1'b1;
                        q_d.hs_nak   = 1'b1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end
   assign prdata   = q_q.prdata;
   assign pready   = q_q.pready;
   assign pslverr  = q_q.pslverr;
   assign hs_valid = q_q.hs_valid;
   assign hs_nak   = q_q.hs_nak;
   assign tx_valid = q_q.tx_valid;
   assign tx_data  = q_q.tx_data;
   assign tx_last  = q_q.tx_last;
   assign tx_zlp   = q_q.tx_zlp;
endmodule
